// File: clock_gen_defines.vh
// Constants for the clock generator status and filter block: APB offsets,
// field positions, mode codes and timing counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH

// Register byte offsets
`define OFS_STATUS_ONE 8'h00
`define OFS_STATUS_TWO 8'h04
`define OFS_FILTER_UPPER 8'h08
`define OFS_FILTER_LOWER 8'h0c
`define OFS_CONTROL 8'h10

// Status one fields
`define S1_MODE_HI 7
`define S1_MODE_LO 6
`define S1_REF 5
`define S1_LOL 4
`define S1_LOCK 3
`define S1_LOC 2
`define S1_EXT 1
`define S1_IRQ 0

// Control fields
`define CTL_SEL_HI 1
`define CTL_SEL_LO 0
`define CTL_LOL_RESP 2
`define CTL_LOC_RESP 3

// Mode codes
`define MODE_SELF 2'h0
`define MODE_ENG_INT 2'h1
`define MODE_BYPASS 2'h2
`define MODE_ENG_EXT 2'h3

// Reset values
`define RST_MODE_SEL 2'h0
`define RST_FILTER 12'h000

// Oscillator stability: allowed count error change and sample run
`define UNLOCK_THRESHOLD 8'h04
`define STABLE_SAMPLES 2'h2

// Filter latch sequence length in clock cycles
`define FLT_LATCH_CYCLES 3'h4

`endif

// File: sync3.v
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous levels; output moves only when stages two
// and three agree.
`timescale 1ns/100ps
`default_nettype none
module sync3 #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // Stage one feeds stage two only, to keep metastability contained
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule // sync3
`default_nettype wire

// File: osc_stable_detect.v
// Oscillator stability detector on loop count error samples.
// Assumes count error and sample strobe come from loop logic on clk_i and
// that the activity level is already synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module osc_stable_detect (
  input wire clk_i,
  input wire sys_rst_i,
  input wire off_i,
  input wire osc_active_i,
  input wire sample_i,
  input wire [7:0] count_error_i,
  output reg stable_o
);

  reg [7:0] prev_error;
  reg [1:0] run;
  wire [7:0] delta;
  wire small_step;

  // Magnitude of change between successive samples
  assign delta = (count_error_i >= prev_error) ? (count_error_i - prev_error)
                                               : (prev_error - count_error_i);
  assign small_step = (delta <= `UNLOCK_THRESHOLD);

  // Off or a static clock drops stability at once; a new run must then build
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_error <= 8'h00;
      run <= 2'h0;
      stable_o <= 1'b0;
    end else if (off_i || !osc_active_i) begin
      run <= 2'h0;
      stable_o <= 1'b0;
    end else if (sample_i) begin
      prev_error <= count_error_i;
      if (!small_step) begin
        run <= 2'h0;
      end else if (run != `STABLE_SAMPLES) begin
        run <= run + 2'h1;
      end
      if (small_step && run >= (`STABLE_SAMPLES - 2'h1)) begin
        stable_o <= 1'b1;
      end
    end
  end

endmodule // osc_stable_detect
`default_nettype wire

// File: clock_gen_status_filter.v
// Status and filter register block of the on-chip clock generator,
// with a compact mode tracker and an APB slave.
// Assumes a zero-wait APB master on clk_i; loop, off and activity signals
// arrive asynchronously from the generator; reference select is on clk_i.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_gen_status_filter (
  input wire clk_i,
  input wire sys_rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Generator side
  input wire off_request_i,
  input wire loop_locked_i,
  input wire clock_lost_i,
  input wire ext_reference_ok_i,
  input wire osc_active_i,
  input wire ref_crystal_sel_i,
  input wire count_sample_i,
  input wire [7:0] count_error_i,
  output reg [1:0] mode_status_o,
  output reg lock_o,
  output reg osc_monitor_en_o,
  output reg [11:0] filter_value_o,
  output reg filter_latch_o,
  output reg interrupt_request_o,
  output reg reset_request_o
);

  // One-hot generator states
  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_SELF = 5'h02;
  localparam [4:0] ST_ENG_INT = 5'h04;
  localparam [4:0] ST_BYPASS = 5'h08;
  localparam [4:0] ST_ENG_EXT = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [1:0] mode_select_field;
  reg lock_loss_response_bit;
  reg clock_loss_response_bit;
  reg loss_of_lock_flag;
  reg loss_of_clock_flag;
  reg clockgen_interrupt_flag;
  reg clear_armed;
  reg clock_lost_prev;
  reg [4:0] state_prev;
  reg wait_stable;
  reg [7:0] lower_hold;
  reg [2:0] latch_count;
  wire [4:0] pins_sync;
  wire [1:0] sel_seen;
  wire off_s;
  wire locked_s;
  wire clock_lost_s;
  wire ext_ok_s;
  wire active_s;
  wire oscillator_stable_bit;
  wire engaged;
  wire lock_now;
  wire lol_event;
  wire loc_event;
  wire irq_event;
  wire [7:0] status_one;
  wire [7:0] status_two;
  wire setup;
  wire access_done;
  wire wr_done;
  wire rd_done;
  wire mapped;
  wire latch_busy;

  // True when an address hits a given register word
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Pins from the generator's own clock come through the agreement filter
  sync3 #(.WIDTH(5)) pin_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({osc_active_i, ext_reference_ok_i, clock_lost_i, loop_locked_i,
              off_request_i}),
    .sync_o(pins_sync)
  );

  assign off_s = pins_sync[0];
  assign locked_s = pins_sync[1];
  assign clock_lost_s = pins_sync[2];
  assign ext_ok_s = pins_sync[3];
  assign active_s = pins_sync[4];

  // Mode select passes the same crossing the generator sees, so status lags
  sync3 #(.WIDTH(2)) sel_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(mode_select_field),
    .sync_o(sel_seen)
  );

  // Stability of the digital oscillator
  osc_stable_detect stable_det (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .off_i(state == ST_OFF),
    .osc_active_i(active_s),
    .sample_i(count_sample_i),
    .count_error_i(count_error_i),
    .stable_o(oscillator_stable_bit)
  );

  // Mode tracker: target mode from the seen select, with entry conditions
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (!off_s) begin
          // External bypass only with a valid reference, else self-clocked
          if (sel_seen == `MODE_BYPASS && ext_ok_s) begin
            next_state = ST_BYPASS;
          end else begin
            next_state = ST_SELF;
          end
        end
      end
      ST_SELF, ST_ENG_INT, ST_BYPASS, ST_ENG_EXT: begin
        if (off_s) begin
          next_state = ST_OFF;
        end else begin
          case (sel_seen)
            `MODE_ENG_INT: begin
              if (!wait_stable || oscillator_stable_bit) begin
                next_state = ST_ENG_INT;
              end
            end
            `MODE_BYPASS: begin
              next_state = ext_ok_s ? ST_BYPASS : ST_SELF;
            end
            `MODE_ENG_EXT: begin
              if (ext_ok_s && oscillator_stable_bit) begin
                next_state = ST_ENG_EXT;
              end else if (!ext_ok_s) begin
                next_state = ST_SELF;
              end
            end
            default: begin
              next_state = ST_SELF;
            end
          endcase
        end
      end
      default: begin
        next_state = ST_SELF;
      end
    endcase
  end

  // State register; after off with an engaged select the engaged modes wait for a stable oscillator
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_SELF;
      state_prev <= ST_SELF;
      wait_stable <= 1'b0;
    end else begin
      state <= next_state;
      state_prev <= state;
      if (state == ST_OFF && next_state != ST_OFF) begin
        wait_stable <= sel_seen[0];
      end else if (oscillator_stable_bit) begin
        wait_stable <= 1'b0;
      end
    end
  end

  assign engaged = (state == ST_ENG_INT) || (state == ST_ENG_EXT);
  // Lock is meaningless outside the engaged modes
  assign lock_now = engaged && locked_s;
  // Unexpected loss: lock drops while the mode has not just changed
  assign lol_event = lock_o && !lock_now && engaged && (state == state_prev);
  assign loc_event = clock_lost_s && !clock_lost_prev;
  assign irq_event = (lol_event && !lock_loss_response_bit) ||
                     (loc_event && !clock_loss_response_bit);

  // APB phases: pready rises in the access cycle, so every transfer is one wait-free access
  assign setup = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_o;
  assign wr_done = access_done && pwrite_i && !pslverr_o;
  assign rd_done = access_done && !pwrite_i && !pslverr_o;
  assign mapped = hit(paddr_i, `OFS_STATUS_ONE) || hit(paddr_i, `OFS_STATUS_TWO) ||
                  hit(paddr_i, `OFS_FILTER_UPPER) || hit(paddr_i, `OFS_FILTER_LOWER) ||
                  hit(paddr_i, `OFS_CONTROL);
  assign latch_busy = (latch_count != 3'h0);

  // Status words as software sees them
  assign status_one = {mode_status_o, ref_crystal_sel_i, loss_of_lock_flag, lock_o,
                       loss_of_clock_flag, ext_ok_s, clockgen_interrupt_flag};
  assign status_two = {7'h00, oscillator_stable_bit};

  // Bus answer; read data is captured in the setup cycle and held
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      if (setup) begin
        pslverr_o <= !mapped;
        prdata_o <= 32'h00000000;
        if (hit(paddr_i, `OFS_STATUS_ONE)) begin
          prdata_o <= {24'h000000, status_one};
        end else if (hit(paddr_i, `OFS_STATUS_TWO)) begin
          prdata_o <= {24'h000000, status_two};
        end else if (hit(paddr_i, `OFS_FILTER_UPPER)) begin
          prdata_o <= {28'h0000000, filter_value_o[11:8]};
        end else if (hit(paddr_i, `OFS_FILTER_LOWER)) begin
          prdata_o <= {24'h000000, filter_value_o[7:0]};
        end else if (hit(paddr_i, `OFS_CONTROL)) begin
          prdata_o <= {28'h0000000, clock_loss_response_bit, lock_loss_response_bit,
                       mode_select_field};
        end
      end else if (access_done) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // Control register written by software
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_select_field <= `RST_MODE_SEL;
      lock_loss_response_bit <= 1'b0;
      clock_loss_response_bit <= 1'b0;
    end else if (wr_done && hit(paddr_i, `OFS_CONTROL)) begin
      mode_select_field <= pwdata_i[`CTL_SEL_HI:`CTL_SEL_LO];
      lock_loss_response_bit <= pwdata_i[`CTL_LOL_RESP];
      clock_loss_response_bit <= pwdata_i[`CTL_LOC_RESP];
    end
  end

  // Sticky loss flags; a new event in the clearing cycle wins
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      loss_of_lock_flag <= 1'b0;
      loss_of_clock_flag <= 1'b0;
      clock_lost_prev <= 1'b0;
    end else begin
      clock_lost_prev <= clock_lost_s;
      if (lol_event) begin
        loss_of_lock_flag <= 1'b1;
      end else if (wr_done && hit(paddr_i, `OFS_STATUS_ONE) && pwdata_i[`S1_LOL]) begin
        loss_of_lock_flag <= 1'b0;
      end
      if (loc_event) begin
        loss_of_clock_flag <= 1'b1;
      end else if (wr_done && hit(paddr_i, `OFS_STATUS_ONE) && pwdata_i[`S1_LOC]) begin
        loss_of_clock_flag <= 1'b0;
      end
    end
  end

  // Interrupt flag with read-then-write-one clearing; a new event disarms
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clockgen_interrupt_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else if (irq_event) begin
      clockgen_interrupt_flag <= 1'b1;
      clear_armed <= 1'b0;
    end else if (rd_done && hit(paddr_i, `OFS_STATUS_ONE) && clockgen_interrupt_flag) begin
      clear_armed <= 1'b1;
    end else if (wr_done && hit(paddr_i, `OFS_STATUS_ONE) && pwdata_i[`S1_IRQ]) begin
      // A zero in this position leaves the flag alone
      if (clear_armed) begin
        clockgen_interrupt_flag <= 1'b0;
        clear_armed <= 1'b0;
      end
    end
  end

  // Responses to loss events: interrupt or reset, as each response bit says
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      interrupt_request_o <= 1'b0;
      reset_request_o <= 1'b0;
    end else begin
      interrupt_request_o <= clockgen_interrupt_flag || irq_event;
      reset_request_o <= (lol_event && lock_loss_response_bit) ||
                         (loc_event && clock_loss_response_bit);
    end
  end

  // Mode and lock reporting; off keeps the last reported mode
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_status_o <= `MODE_SELF;
      lock_o <= 1'b0;
      osc_monitor_en_o <= 1'b0;
    end else begin
      lock_o <= lock_now;
      osc_monitor_en_o <= (state == ST_SELF) && oscillator_stable_bit;
      case (state)
        ST_SELF: mode_status_o <= `MODE_SELF;
        ST_ENG_INT: mode_status_o <= `MODE_ENG_INT;
        ST_BYPASS: mode_status_o <= `MODE_BYPASS;
        ST_ENG_EXT: mode_status_o <= `MODE_ENG_EXT;
        default: mode_status_o <= mode_status_o;
      endcase
    end
  end

  // Filter value: lower byte held until the upper write commits all 12 bits.
  // The latch window models hand-over to the oscillator; upper writes inside
  // it are dropped rather than queued, so software must pace its updates.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filter_value_o <= `RST_FILTER;
      lower_hold <= 8'h00;
      latch_count <= 3'h0;
      filter_latch_o <= 1'b0;
    end else begin
      filter_latch_o <= 1'b0;
      if (latch_busy) begin
        latch_count <= latch_count - 3'h1;
      end
      if (wr_done && mode_select_field == `MODE_SELF) begin
        if (hit(paddr_i, `OFS_FILTER_LOWER)) begin
          lower_hold <= pwdata_i[7:0];
        end else if (hit(paddr_i, `OFS_FILTER_UPPER) && !latch_busy) begin
          filter_value_o <= {pwdata_i[3:0], lower_hold};
          latch_count <= `FLT_LATCH_CYCLES;
          filter_latch_o <= 1'b1;
        end
      end
    end
  end

endmodule // clock_gen_status_filter
`default_nettype wire

// File: clock_gen_status_filter_checker.sv
// Port-level checker for the clock generator status and filter block.
// Assumes only the top module's ports; attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_gen_status_filter_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] mode_status_o,
  input wire logic lock_o,
  input wire logic [11:0] filter_value_o,
  input wire logic filter_latch_o,
  input wire logic reset_request_o
);
  // Completed access and the set of decoded offsets
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic mapped = paddr_i inside {`OFS_STATUS_ONE, `OFS_STATUS_TWO,
    `OFS_FILTER_UPPER, `OFS_FILTER_LOWER, `OFS_CONTROL};
  wire logic no_loop = mode_status_o inside {`MODE_SELF, `MODE_BYPASS};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr_o)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (acc && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  // Status must not jump on the select write: it crosses a synchroniser
  a_mode_select_lag: assert property (acc && pwrite_i && paddr_i == `OFS_CONTROL
    |=> $stable(mode_status_o) [*2])
    else $error("mode status moved too soon");
  a_lock_forced_low: assert property (no_loop && $past(no_loop) |-> !lock_o)
    else $error("lock shown outside loop mode");
  a_filter_needs_write: assert property ($changed(filter_value_o)
    |-> $past(psel_i && penable_i && pwrite_i && paddr_i == `OFS_FILTER_UPPER))
    else $error("filter changed without upper write");
  a_latch_holdoff: assert property ($rose(filter_latch_o)
    |=> !filter_latch_o [*3])
    else $error("filter latch retriggered");
  a_reset_req_pulse: assert property (reset_request_o |=> !reset_request_o)
    else $error("reset request not a pulse");
endmodule // clock_gen_status_filter_checker

bind clock_gen_status_filter clock_gen_status_filter_checker chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mode_status_o(mode_status_o), .lock_o(lock_o), .filter_value_o(filter_value_o),
  .filter_latch_o(filter_latch_o), .reset_request_o(reset_request_o));
`default_nettype wire

// File: clock_gen_status_filter_bench.sv
// Self-checking bench for the clock generator status and filter block.
// Assumes the design answers APB with pready and drives generator inputs itself.
`timescale 1ns/100ps
`default_nettype none
module clock_gen_status_filter_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic off_request_i = 1'b0, loop_locked_i = 1'b0, clock_lost_i = 1'b0;
  logic ext_reference_ok_i = 1'b0, osc_active_i = 1'b0, ref_crystal_sel_i = 1'b0;
  logic count_sample_i = 1'b0;
  logic [7:0] count_error_i = 8'h10;
  logic [1:0] mode_status_o;
  logic lock_o, osc_monitor_en_o, filter_latch_o, interrupt_request_o, reset_request_o;
  logic [11:0] filter_value_o;
  int err_count = 0, comparisons = 0, rst_pulses = 0;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, m, e; logic er;} row_t;
  row_t rows[8];
  clock_gen_status_filter dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .off_request_i(off_request_i), .loop_locked_i(loop_locked_i),
    .clock_lost_i(clock_lost_i), .ext_reference_ok_i(ext_reference_ok_i),
    .osc_active_i(osc_active_i), .ref_crystal_sel_i(ref_crystal_sel_i),
    .count_sample_i(count_sample_i), .count_error_i(count_error_i),
    .mode_status_o(mode_status_o), .lock_o(lock_o), .osc_monitor_en_o(osc_monitor_en_o),
    .filter_value_o(filter_value_o), .filter_latch_o(filter_latch_o),
    .interrupt_request_o(interrupt_request_o), .reset_request_o(reset_request_o));
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Reset requests are single-cycle pulses, so count them as they pass
  always @(posedge clk_i) begin
    if (reset_request_o === 1'b1) rst_pulses <= rst_pulses + 1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One APB transfer; no wait count is assumed, only a bound on the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) chk("pready wait", 1, 0);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rd & m);
  endtask
  task automatic sample();
    @(posedge clk_i);
    count_sample_i <= 1'b1;
    @(posedge clk_i);
    count_sample_i <= 1'b0;
  endtask
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 5);
    err_count++;
    end_sim();
  end
  initial begin
    rows[0] = '{0, 8'h00, 0, 32'hff, 32'h00, 0};
    rows[1] = '{0, 8'h04, 0, 32'h01, 32'h00, 0};
    rows[2] = '{0, 8'h14, 0, 32'hffffffff, 32'h0, 1};
    rows[3] = '{1, 8'h0c, 32'h5a, 0, 0, 0};
    rows[4] = '{1, 8'h08, 32'hc3, 0, 0, 0};
    rows[5] = '{0, 8'h08, 0, 32'h0f, 32'h03, 0};
    rows[6] = '{0, 8'h0c, 0, 32'hff, 32'h5a, 0};
    rows[7] = '{1, 8'h20, 32'h1, 0, 0, 1};
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("row data", rows[i].e, rd & rows[i].m);
      chk("row error", rows[i].er, er);
    end
    chk("filter", 12'h35a, filter_value_o);
    // An upper write right behind a commit lands in the latch window and is dropped
    apb(1'b1, 8'h08, 32'h0c);
    apb(1'b1, 8'h08, 32'h01);
    wt(1);
    chk("filter busy", 12'hc5a, filter_value_o);
    chk("latch busy", 0, filter_latch_o);
    wt(6);
    apb(1'b1, 8'h08, 32'h0f);
    wt(1);
    chk("filter", 12'hf5a, filter_value_o);
    chk("latch", 1, filter_latch_o);
    ref_crystal_sel_i <= 1'b1;
    ext_reference_ok_i <= 1'b1;
    osc_active_i <= 1'b1;
    wt(8);
    rdchk(8'h00, 32'h22, 32'h22);
    repeat (3) sample();
    wt(6);
    rdchk(8'h04, 32'h01, 32'h01);
    chk("monitor", 1, osc_monitor_en_o);
    // Loop engaged on internal reference: filter is read-only there
    apb(1'b1, 8'h10, 32'h01);
    wt(12);
    chk("mode", 2'h1, mode_status_o);
    apb(1'b1, 8'h08, 32'h01);
    wt(6);
    chk("filter ro", 12'hf5a, filter_value_o);
    loop_locked_i <= 1'b1;
    wt(8);
    chk("lock", 1, lock_o);
    loop_locked_i <= 1'b0;
    wt(8);
    rdchk(8'h00, 32'h11, 32'h11);
    chk("irq", 1, interrupt_request_o);
    apb(1'b1, 8'h00, 32'h0);
    rdchk(8'h00, 32'h01, 32'h01);
    // A new clock loss between read and clearing write keeps the flag
    clock_lost_i <= 1'b1;
    wt(8);
    apb(1'b1, 8'h00, 32'h01);
    rdchk(8'h00, 32'h05, 32'h05);
    apb(1'b1, 8'h00, 32'h15);
    wt(2);
    rdchk(8'h00, 32'h15, 32'h00);
    // Reset responses: a loss event pulses a reset request, no interrupt
    apb(1'b1, 8'h10, 32'h0d);
    clock_lost_i <= 1'b0;
    wt(8);
    clock_lost_i <= 1'b1;
    wt(8);
    chk("reset pulses", 1, rst_pulses);
    rdchk(8'h00, 32'h01, 32'h00);
    // Loop stays locked while the mode walks through bypass, ext loop and self
    loop_locked_i <= 1'b1;
    apb(1'b1, 8'h10, 32'h02);
    wt(12);
    chk("mode bypass", 2'h2, mode_status_o);
    chk("lock bypass", 0, lock_o);
    apb(1'b1, 8'h10, 32'h03);
    wt(12);
    chk("mode ext loop", 2'h3, mode_status_o);
    chk("lock ext loop", 1, lock_o);
    apb(1'b1, 8'h10, 32'h00);
    wt(12);
    chk("mode self", 2'h0, mode_status_o);
    chk("lock self", 0, lock_o);
    // Leaving off with an engaged select must wait for the oscillator again
    apb(1'b1, 8'h10, 32'h01);
    off_request_i <= 1'b1;
    wt(8);
    rdchk(8'h04, 32'h01, 32'h00);
    off_request_i <= 1'b0;
    wt(12);
    chk("mode wait", 2'h0, mode_status_o);
    repeat (2) sample();
    wt(12);
    chk("mode engaged", 2'h1, mode_status_o);
    // Mid-run reset returns filter and mode to their reset values
    sys_rst_i <= 1'b1;
    wt(2);
    sys_rst_i <= 1'b0;
    wt(1);
    chk("filter rst", 12'h000, filter_value_o);
    chk("mode rst", 2'h0, mode_status_o);
    end_sim();
  end
endmodule // clock_gen_status_filter_bench
`default_nettype wire
